//--- verilog/ssr_status_top.sv
// Status byte, service request enable and host query handling
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Enabled set status bits raise service request
// - Eight-bit request mask maps onto status byte
// - Request mask is zero after reset
// - Status bit six cannot be masked
// - Status bits 0-3 read zero, masks inert
// - Enabled operation events summarise into bit seven
// - Condition register follows state; unused bits zero
// - Condition bit four shows measurement running
// - Condition bit three shows sweep running
// - Condition bit zero shows correction running
// - Condition query leaves register unchanged
// - Sixteen event bits pair with condition bits
// - Event set only on falling condition
// - Event bits mark measurement/sweep/correction completion
// - Event query returns then clears, bit seven drops
// - Bit seven set by any enabled event
// - Event enable mask sixteen bits, own command
// - Poll shows and clears RQS; query shows MSS
// - Bit four shows waiting data, poll keeps it
module ssr_status_top
   import ssr_pkg::*;
(
   input  wire logic      i_mclk,     // 40 MHz clock
   input  wire logic      i_sys_rst,  // Synchronous reset, active high
   input  wire ssr_cmd_t  i_cmd,      // Host command strobes
   input  wire ssr_live_t i_live,     // Live device state
   output logic [15:0]    o_rdata,    // Answer to the last query
   output logic           o_rvalid,   // One-cycle answer strobe
   output logic           o_srq       // Service request line
);
   typedef enum logic [1:0] {ST_IDLE, ST_ANSWER} ssr_phase_t;

   // All top state in one record
   typedef struct packed {
      ssr_phase_t  phase;   // Answer phase
      logic [7:0]  sre;     // Request enable mask
      logic        rqs;     // Request service flag
      logic        mss_q;   // Previous master summary
      logic [15:0] rdata;   // Answer data
      logic        rvalid;  // Answer strobe
   } ssr_top_t;

   ssr_top_t    st_ff;    // Registered state
   ssr_top_t    nxt_st;   // Next state
   logic [15:0] cond_w;   // Condition register
   logic [15:0] event_w;  // Event latch
   logic [15:0] oen_w;    // Event enable mask
   logic        ops_w;    // Operation summary
   logic        mss_w;    // Master summary
   logic [7:0]  stb_w;    // Status byte without bit 6

   // Operation status group
   ssr_op_group u_opg (
      .i_mclk     (i_mclk),
      .i_sys_rst  (i_sys_rst),
      .i_live     (i_live),
      .i_wr_oen   (i_cmd.wr_oen),
      .i_wdata    (i_cmd.wdata),
      .i_rd_event (i_cmd.rd_event),
      .o_cond     (cond_w),
      .o_event    (event_w),
      .o_oen      (oen_w),
      .o_summary  (ops_w)
   );

   // Status byte; low nibble is hardwired zero
   function automatic logic [7:0] ssr_stb(input logic ops, input logic mav);
      logic [7:0] b;
      b = 8'h00;
      b[SSR_SB_OPS] = ops;
      b[SSR_SB_MAV] = mav;
      return b;
   endfunction

   always_comb begin
      stb_w = ssr_stb(ops_w, i_live.mav);
   end

   // Master summary path
   ssr_srq_gen u_srq (
      .i_stb_low (stb_w),
      .i_sre     (st_ff.sre),
      .o_mss     (mss_w)
   );

   // Next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rvalid = 1'b0;
      nxt_st.phase  = ST_IDLE;
      nxt_st.mss_q  = mss_w;
      if (i_cmd.wr_sre) begin
         nxt_st.sre = i_cmd.wdata[7:0];
      end
      // Poll clears the flag; a new rising summary in that cycle still sets it
      if (i_cmd.spoll) begin
         nxt_st.rqs = 1'b0;
      end
      if (mss_w && !st_ff.mss_q) begin
         nxt_st.rqs = 1'b1;
      end
      case (st_ff.phase)
         ST_IDLE, ST_ANSWER: begin
            // One query per cycle; poll wins, then status byte, then registers
            if (i_cmd.spoll) begin
               nxt_st.rdata = {8'h00, stb_w | ({7'h00, st_ff.rqs} << SSR_SB_RQS)};
               nxt_st.rvalid = 1'b1;
               nxt_st.phase  = ST_ANSWER;
            end else if (i_cmd.rd_stb) begin
               nxt_st.rdata = {8'h00, stb_w | ({7'h00, mss_w} << SSR_SB_RQS)};
               nxt_st.rvalid = 1'b1;
               nxt_st.phase  = ST_ANSWER;
            end else if (i_cmd.rd_cond) begin
               nxt_st.rdata = cond_w;
               nxt_st.rvalid = 1'b1;
               nxt_st.phase  = ST_ANSWER;
            end else if (i_cmd.rd_event) begin
               nxt_st.rdata = event_w;
               nxt_st.rvalid = 1'b1;
               nxt_st.phase  = ST_ANSWER;
            end
         end
         default: begin
            nxt_st.phase = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         st_ff <= '{phase: ST_IDLE, sre: SSR_SRE_RST, rqs: 1'b0, mss_q: 1'b0,
                    rdata: 16'h0000, rvalid: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flip-flops
   assign o_rdata  = st_ff.rdata;
   assign o_rvalid = st_ff.rvalid;
   assign o_srq    = st_ff.rqs;

   chk_sre_reset: assert property (@(posedge i_mclk)
      $fell(i_sys_rst) |-> st_ff.sre == SSR_SRE_RST)
      else $error("mask not zero after reset");
   chk_srq_raise: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (mss_w && !st_ff.mss_q) |=> o_srq)
      else $error("request not raised");
   chk_poll_clears: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_cmd.spoll && !(mss_w && !st_ff.mss_q)) |=> !o_srq ##0 o_rvalid)
      else $error("poll did not clear request");
   chk_low_nibble: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (o_rvalid && $past(i_cmd.spoll || i_cmd.rd_stb)) |-> o_rdata[3:0] == 4'h0)
      else $error("low status bits not zero");
   chk_bit6_inert: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (st_ff.sre == 8'h40) |-> !mss_w)
      else $error("bit six mask took effect");
   chk_cond_query: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_cmd.rd_cond && !i_cmd.spoll && !i_cmd.rd_stb) |=> o_rdata == $past(cond_w))
      else $error("condition answer wrong");
   chk_event_clear: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_cmd.rd_event && cond_w == 16'h0000 && i_live == '0) |=> !ops_w)
      else $error("summary not cleared by event query");

   cov_poll: cover property (@(posedge i_mclk) o_srq ##1 i_cmd.spoll);
   cov_event: cover property (@(posedge i_mclk) ops_w ##1 i_cmd.rd_event);
   cov_stb: cover property (@(posedge i_mclk) mss_w && i_cmd.rd_stb);
endmodule
`default_nettype wire

//--- verilog/ssr_pkg.sv
// Shared types and constants for the status service request logic
package ssr_pkg;
   localparam int unsigned SSR_SB_W      = 8;      // Status byte width
   localparam int unsigned SSR_OP_W      = 16;     // Operation registers width
   localparam int unsigned SSR_SB_OPS    = 7;      // Operation summary position
   localparam int unsigned SSR_SB_RQS    = 6;      // Request service position
   localparam int unsigned SSR_SB_MAV    = 4;      // Message available position
   localparam int unsigned SSR_OP_MEAS   = 4;      // Single measurement bit
   localparam int unsigned SSR_OP_SWEEP  = 3;      // List sweep bit
   localparam int unsigned SSR_OP_CORR   = 0;      // Correction measurement bit
   localparam logic [7:0]  SSR_SRE_RST   = 8'h00;  // Request mask after reset
   localparam logic [7:0]  SSR_SRE_USED  = 8'hb0;  // Mask bits that take effect
   localparam logic [15:0] SSR_OEN_RST   = 16'h0000; // Event mask after reset
   localparam logic [15:0] SSR_OP_LIVE   = 16'h0019; // Implemented op bits
   localparam logic [15:0] SSR_OEV_RST   = 16'h0000; // Event latch after reset

   // Host command strobes with their data
   typedef struct packed {
      logic        wr_sre;     // Write request enable mask
      logic        wr_oen;     // Write operation event enable mask
      logic [15:0] wdata;      // Written value
      logic        rd_cond;    // Query condition register
      logic        rd_event;   // Query event latch (clears it)
      logic        rd_stb;     // Status byte query
      logic        spoll;      // Serial poll
   } ssr_cmd_t;

   // Live device state inputs
   typedef struct packed {
      logic meas;              // Single measurement running
      logic sweep;             // List sweep running
      logic corr;              // Correction measurement running
      logic mav;               // Output data waiting
   } ssr_live_t;
endpackage

//--- verilog/ssr_op_group.sv
// Operation status group: condition, negative-edge event latch, summary
`timescale 1ns/1ps
`default_nettype none
module ssr_op_group
   import ssr_pkg::*;
(
   input  wire logic              i_mclk,      // System clock
   input  wire logic              i_sys_rst,   // Synchronous reset
   input  wire ssr_live_t         i_live,      // Live device state
   input  wire logic              i_wr_oen,    // Write event enable mask
   input  wire logic [15:0]       i_wdata,     // Mask data
   input  wire logic              i_rd_event,  // Event query, clears latch
   output logic [15:0]            o_cond,      // Condition register
   output logic [15:0]            o_event,     // Event latch
   output logic [15:0]            o_oen,       // Event enable mask
   output logic                   o_summary    // Status byte bit 7 source
);
   // All state of this group in one record
   typedef struct packed {
      logic [15:0] cond;
      logic [15:0] evt;
      logic [15:0] oen;
   } ssr_opg_t;

   ssr_opg_t st_ff;   // Registered state
   ssr_opg_t nxt_st;  // Next state
   logic [15:0] live_w; // Live condition word

   // Unused positions are forced low so they can never make an event
   always_comb begin
      live_w = '0;
      live_w[SSR_OP_MEAS]  = i_live.meas;
      live_w[SSR_OP_SWEEP] = i_live.sweep;
      live_w[SSR_OP_CORR]  = i_live.corr;
      live_w = live_w & SSR_OP_LIVE;
   end

   // Next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.cond = live_w;
      // Read clears first, then new falls set: an edge during the read survives
      if (i_rd_event) begin
         nxt_st.evt = '0;
      end
      nxt_st.evt = nxt_st.evt | (st_ff.cond & ~live_w);
      if (i_wr_oen) begin
         nxt_st.oen = i_wdata;
      end
   end

   // State register
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         st_ff <= '{cond: 16'h0000, evt: SSR_OEV_RST, oen: SSR_OEN_RST};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_cond    = st_ff.cond;
   assign o_event   = st_ff.evt;
   assign o_oen     = st_ff.oen;
   assign o_summary = |(st_ff.evt & st_ff.oen);

   chk_event_on_fall: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (st_ff.cond[SSR_OP_MEAS] && !live_w[SSR_OP_MEAS]) |=> st_ff.evt[SSR_OP_MEAS])
      else $error("fall did not set event");
   chk_no_rise_evt: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (!st_ff.evt[SSR_OP_SWEEP] && $rose(st_ff.cond[SSR_OP_SWEEP])
       && live_w[SSR_OP_SWEEP] && !i_rd_event)
      |=> !st_ff.evt[SSR_OP_SWEEP])
      else $error("rise set event");
   chk_cond_zeros: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (st_ff.cond & ~SSR_OP_LIVE) == 16'h0000)
      else $error("reserved condition bit set");
   chk_event_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (!i_rd_event && st_ff.evt[SSR_OP_CORR]) |=> st_ff.evt[SSR_OP_CORR])
      else $error("event bit lost");
endmodule
`default_nettype wire

//--- verilog/ssr_srq_gen.sv
// Service request generation from status byte and request mask
`timescale 1ns/1ps
`default_nettype none
module ssr_srq_gen
   import ssr_pkg::*;
(
   input  wire logic [7:0] i_stb_low,  // Status byte without bit 6
   input  wire logic [7:0] i_sre,      // Stored request enable mask
   output logic            o_mss       // Master summary
);
   // Bit 6 and bits 0..3 of the mask are stored but never used
   assign o_mss = |(i_stb_low & i_sre & SSR_SRE_USED);
endmodule
`default_nettype wire

//--- testbench/ssr_host_model.sv
// Host controller model issuing status commands and queries
`timescale 1ns/1ps
`default_nettype none
module ssr_host_model
   import ssr_pkg::*;
(
   input  wire logic        i_mclk,    // System clock
   input  wire logic [15:0] i_rdata,   // Answer data
   input  wire logic        i_rvalid,  // Answer strobe
   output var  ssr_cmd_t    o_cmd      // Command strobes
);
   initial o_cmd = '0;

   // One-cycle mask write; data is scrambled after so nothing relies on it
   task automatic wr(input bit oen, input logic [15:0] v);
      @(posedge i_mclk) #1;
      o_cmd.wdata  = v;
      o_cmd.wr_oen = oen;
      o_cmd.wr_sre = !oen;
      @(posedge i_mclk) #1;
      o_cmd.wr_oen = 1'b0;
      o_cmd.wr_sre = 1'b0;
      o_cmd.wdata  = ~v;
   endtask

   // Query kinds: 0 condition, 1 event, 2 status byte, 3 serial poll
   task automatic qry(input int k, output logic [15:0] d, output logic ok);
      @(posedge i_mclk) #1;
      o_cmd.rd_cond  = (k == 0);
      o_cmd.rd_event = (k == 1);
      o_cmd.rd_stb   = (k == 2);
      o_cmd.spoll    = (k == 3);
      @(posedge i_mclk) #1;
      {o_cmd.rd_cond, o_cmd.rd_event, o_cmd.rd_stb, o_cmd.spoll} = 4'h0;
      ok = i_rvalid;
      d  = i_rdata;
   endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the status service request logic
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ssr_pkg::*;
   logic        i_mclk;     // Clock
   logic        i_sys_rst;  // Reset
   ssr_live_t   live;       // Device state
   ssr_cmd_t    cmd;        // Host strobes
   logic [15:0] rdata;      // Answer data
   logic        rvalid;     // Answer strobe
   logic        srq;        // Service request
   logic [15:0] d;          // Last answer
   logic        ok;         // Last strobe
   int n_fail = 0, n_checks = 0, seed = 60807, cyc = 0;
   int m_cond = 0, m_ev = 0, m_oen = 0, m_mav = 0;  // Reference model

   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end

   ssr_status_top u_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cmd(cmd),
      .i_live(live), .o_rdata(rdata), .o_rvalid(rvalid), .o_srq(srq));
   ssr_host_model u_host (.i_mclk(i_mclk), .i_rdata(rdata), .i_rvalid(rvalid),
      .o_cmd(cmd));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Hang guard: the run needs well under a thousand cycles
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc > 5000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, w, got, exp);
      end
   endtask

   // A query must be answered one cycle later with the model's value
   task automatic q(input int k, input int exp, input string w);
      u_host.qry(k, d, ok);
      chk({15'h0, ok}, 16'h1, "answer strobe");
      chk(d, exp[15:0], w);
   endtask

   // Status byte from the model, bit 6 given by the caller
   function automatic int m_stb(input int b6);
      return (((m_ev & m_oen) != 0) << 7) | (b6 << 6) | (m_mav << 4);
   endfunction

   // Drive live state {meas,sweep,corr,mav}; falls latch events in the model
   task automatic setl(input logic [3:0] v);
      int c;
      c = v[3] * 16 + v[2] * 8 + v[1];
      @(posedge i_mclk) #1;
      live = v;
      m_ev |= m_cond & ~c;
      m_cond = c;
      m_mav = v[0];
      repeat (4) @(posedge i_mclk);
   endtask

   initial begin
      logic [3:0] r;
      i_sys_rst = 1'b1;
      live = '0;
      repeat (8) @(posedge i_mclk);
      #1 i_sys_rst = 1'b0;
      chk({15'h0, srq}, 16'h0, "srq after reset");
      q(2, 0, "stb after reset");
      $display("test reset done");
      // Random state changes; condition follows, events only on falls
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         setl({r[3:1], 1'b0});
         q(0, m_cond, "condition");
         q(0, m_cond, "condition reread");
         q(1, m_ev, "event latch");
         m_ev = 0;
         q(1, 0, "event after read");
      end
      setl(4'h0);
      q(1, m_ev, "event drain");
      m_ev = 0;
      $display("test condition events done");
      // Summary into bit 7 and service request on it
      u_host.wr(1'b1, 16'h0008);
      m_oen = 8;
      setl(4'b0100);
      q(2, m_stb(0), "no event on rise");
      setl(4'b0000);
      q(2, m_stb(0), "summary bit");
      u_host.wr(1'b0, 16'hff4f);
      repeat (3) @(posedge i_mclk);
      chk({15'h0, srq}, 16'h0, "bit 6 and low bits inert");
      u_host.wr(1'b0, 16'h0080);
      repeat (3) @(posedge i_mclk);
      chk({15'h0, srq}, 16'h1, "srq raised");
      q(2, m_stb(1), "stb shows mss");
      chk({15'h0, srq}, 16'h1, "stb keeps srq");
      q(3, m_stb(1), "poll shows rqs");
      chk({15'h0, srq}, 16'h0, "poll clears srq");
      q(3, m_stb(0), "rqs cleared");
      q(1, m_ev, "event read");
      m_ev = 0;
      q(2, m_stb(0), "summary cleared");
      $display("test summary srq done");
      // Waiting output data, enabled through bit 4
      u_host.wr(1'b0, 16'h0010);
      setl(4'b0001);
      chk({15'h0, srq}, 16'h1, "mav request");
      q(3, m_stb(1), "poll mav");
      q(3, m_stb(0), "mav survives poll");
      setl(4'b0000);
      q(2, m_stb(0), "mav read");
      $display("test message available done");
      // Reset in mid-run clears both masks
      u_host.wr(1'b1, 16'hffff);
      @(posedge i_mclk) #1;
      i_sys_rst = 1'b1;
      repeat (2) @(posedge i_mclk);
      #1 i_sys_rst = 1'b0;
      m_oen = 0;
      setl(4'b0001);
      chk({15'h0, srq}, 16'h0, "mask zero after reset");
      q(2, m_stb(0), "stb after reset");
      $display("test second reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
